// file: src/sdaa_core.sv
// Address-assignment sequencer of a gate driver on a shared SPI bus.
// Assumes an SPI front end decodes frames into one-cycle command pulses.
//
// Behaviour
// - Individual addresses one to fourteen accepted
// - Address fifteen is broadcast, all respond
// - Fault indicators high on entering first configuration
// - Address assignment only in first configuration
// - Noninverting PWM input high qualifies address write
// - Accepted write stores address in assigned field
// - Broadcast advance command locks address, enters second
`timescale 1ns/1ps
`include "sdaa_params.svh"

module sdaa_core (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic startup_done_i,
	input wire logic startup_fault_i,
	input wire logic pwm_noninv_i,
	input wire logic write_address_command_i,
	input wire logic cfg_advance_cmd_i,
	input wire logic [3:0] frame_addr_i,
	input wire logic [3:0] cmd_addr_data_i,
	output logic [3:0] assigned_device_address_o,
	output logic addr_locked_o,
	output logic [1:0] fault_indicator_outputs_o,
	output logic config2_o,
	output logic frame_hit_o
);
	// Current and next configuration state
	sdaa_pkg::sdaa_state_t state, next_state;
	// Assigned device address field, four bits wide
	logic [`SDAA_ADDR_W-1:0] addr, next_addr;
	// Set once by the broadcast advance, cleared only by reset
	logic locked, next_locked;
	// Both fault indicator outputs, low until first configuration
	logic [1:0] flt, next_flt;
	// Registered answer: a command one cycle ago addressed this device
	logic hit_q, next_hit_q;
	// Registered copy of the second-configuration state, so the pin is a flop
	logic cfg2, next_cfg2;
	// Combinational match results
	logic hit, bcast;

	// Valid individual address; zero and broadcast are refused
	// A function so that the next-state logic and the checks agree
	function automatic logic addr_legal(input logic [3:0] a);
		addr_legal = (a >= `SDAA_ADDR_MIN) && (a <= `SDAA_ADDR_MAX);
	endfunction

	// Own-or-broadcast match, kept apart so the compare logic stays small
	sdaa_match i_sdaa_match (
		.frame_addr_i(frame_addr_i),
		.own_addr_i(addr),
		.hit_o(hit),
		.bcast_o(bcast)
	);

	// Next-state computation for the whole sequencer
	// State, address, lock and indicators default to the present value, so no path infers a latch
	always_comb begin
		next_state = state;
		next_addr = addr;
		next_locked = locked;
		next_flt = flt;
		// The answer pulse follows any matching command, in any state
		next_hit_q = (write_address_command_i || cfg_advance_cmd_i) && hit;
		case (state)
			sdaa_pkg::SDAA_STARTUP: begin
				// Fault during startup keeps indicators low, no addressing
				if (startup_done_i && !startup_fault_i) begin
					next_state = sdaa_pkg::SDAA_CONFIG1;
					// Both indicators rise together to mark the new state
					next_flt = 2'h3;
				end
			end
			sdaa_pkg::SDAA_CONFIG1: begin
				// Write taken only with PWM high; a broadcast write is honoured
				// since every device answers it, host must avoid on shared bus
				if (write_address_command_i && pwm_noninv_i && hit
						&& addr_legal(cmd_addr_data_i)) begin
					next_addr = cmd_addr_data_i;
				end
				// Advance only on broadcast; individual advance ignored
				if (cfg_advance_cmd_i && bcast) begin
					// Lock and state change in one edge, so no write slips between
					next_locked = 1'h1;
					next_state = sdaa_pkg::SDAA_CONFIG2;
				end
			end
			sdaa_pkg::SDAA_CONFIG2: begin
				// Address frozen; further writes ignored until reset
				next_state = state;
			end
			default: begin
				// Unused encoding: fall back to startup rather than hang
				next_state = sdaa_pkg::SDAA_STARTUP;
			end
		endcase
		// Output flag tracks the state that follows this edge
		next_cfg2 = (next_state == sdaa_pkg::SDAA_CONFIG2);
	end

	// Register stage, synchronous reset
	// Only this process writes the state; the block above only computes
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			// Constant reset values, so every output starts low
			state <= sdaa_pkg::SDAA_STARTUP;
			addr <= `SDAA_ADDR_RESET;
			locked <= 1'h0;
			flt <= 2'h0;
			hit_q <= 1'h0;
			cfg2 <= 1'h0;
		end else begin
			// Normal operation: take the computed next values
			state <= next_state;
			addr <= next_addr;
			locked <= next_locked;
			flt <= next_flt;
			hit_q <= next_hit_q;
			cfg2 <= next_cfg2;
		end
	end

	// Outputs straight from flip-flops
	// Plain copies of registers; no logic between flop and pin
	always_comb begin
		assigned_device_address_o = addr;
		addr_locked_o = locked;
		fault_indicator_outputs_o = flt;
		config2_o = cfg2;
		frame_hit_o = hit_q;
	end

	// Checks next to the logic
	// All checks share the one clock and are off while reset is held
	sequence s_good_write;
		write_address_command_i && pwm_noninv_i && hit && addr_legal(cmd_addr_data_i)
			&& state == sdaa_pkg::SDAA_CONFIG1;
	endsequence

	a_addr_store: assert property (@(posedge clock_i) disable iff (rst_i)
		s_good_write |=> addr == $past(cmd_addr_data_i))
		else $error("accepted address not stored");
	a_pwm_gate: assert property (@(posedge clock_i) disable iff (rst_i)
		!pwm_noninv_i |=> $stable(addr))
		else $error("address changed with pwm low");
	a_state_gate: assert property (@(posedge clock_i) disable iff (rst_i)
		state != sdaa_pkg::SDAA_CONFIG1 |=> $stable(addr))
		else $error("address changed outside first configuration");
	a_addr_range: assert property (@(posedge clock_i) disable iff (rst_i)
		$changed(addr) && !$past(rst_i) |-> addr >= 4'h1 && addr <= 4'hE)
		else $error("illegal address stored");
	a_bcast_adv: assert property (@(posedge clock_i) disable iff (rst_i)
		state == sdaa_pkg::SDAA_CONFIG1 && cfg_advance_cmd_i && frame_addr_i == 4'hF
			|=> config2_o && addr_locked_o)
		else $error("broadcast advance not taken");
	a_bcast_hit: assert property (@(posedge clock_i) disable iff (rst_i)
		write_address_command_i && frame_addr_i == 4'hF |=> frame_hit_o)
		else $error("broadcast not answered");
	a_flt_enter: assert property (@(posedge clock_i) disable iff (rst_i)
		state == sdaa_pkg::SDAA_STARTUP && startup_done_i && !startup_fault_i
			|=> fault_indicator_outputs_o == 2'h3 ##1 fault_indicator_outputs_o == 2'h3)
		else $error("fault indicators not raised");
	a_lock_hold: assert property (@(posedge clock_i) disable iff (rst_i)
		addr_locked_o |=> addr_locked_o && $stable(addr))
		else $error("locked address moved");
	a_fault_stay: assert property (@(posedge clock_i) disable iff (rst_i)
		state == sdaa_pkg::SDAA_STARTUP && startup_fault_i |=> fault_indicator_outputs_o == 2'h0)
		else $error("indicators high after startup fault");

	// A command that matches this device; the answer pulse must follow
	sequence s_cmd_hit;
		(write_address_command_i || cfg_advance_cmd_i) && hit;
	endsequence

	// A cycle with no matching command at all
	sequence s_no_hit;
		!((write_address_command_i || cfg_advance_cmd_i) && hit);
	endsequence

	// Broadcast advance seen in the first configuration state
	sequence s_bcast_adv;
		state == sdaa_pkg::SDAA_CONFIG1 && cfg_advance_cmd_i && bcast;
	endsequence

	// Answer pulse: one cycle after a match, and only then
	a_hit_pulse: assert property (@(posedge clock_i) disable iff (rst_i)
		s_cmd_hit |=> frame_hit_o)
		else $error("matching command not answered");
	a_hit_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
		s_no_hit |=> !frame_hit_o)
		else $error("answer pulse without a matching command");
	// Refused writes leave the field untouched
	a_data_refuse: assert property (@(posedge clock_i) disable iff (rst_i)
		write_address_command_i && !addr_legal(cmd_addr_data_i) |=> $stable(addr))
		else $error("out of range address data stored");
	a_miss_ignore: assert property (@(posedge clock_i) disable iff (rst_i)
		write_address_command_i && !hit |=> $stable(addr))
		else $error("write for another device stored");
	// Only the broadcast advance may leave the first configuration
	a_adv_refuse: assert property (@(posedge clock_i) disable iff (rst_i)
		state == sdaa_pkg::SDAA_CONFIG1 && cfg_advance_cmd_i && !bcast |=> !config2_o)
		else $error("individual advance left first configuration");
	a_cfg2_enter: assert property (@(posedge clock_i) disable iff (rst_i)
		s_bcast_adv |=> config2_o ##1 (config2_o && addr_locked_o))
		else $error("second configuration not held");
	// Both reached states are kept until reset
	a_cfg2_hold: assert property (@(posedge clock_i) disable iff (rst_i)
		config2_o |=> config2_o)
		else $error("second configuration left");
	a_flt_hold: assert property (@(posedge clock_i) disable iff (rst_i)
		fault_indicator_outputs_o == 2'h3 |=> fault_indicator_outputs_o == 2'h3)
		else $error("fault indicators fell");
endmodule

// file: src/sdaa_params.svh
// Constants for the address-assignment sequencer of the gate driver.
// Assumes inclusion by bare name; definitions only.
`ifndef SDAA_PARAMS_SVH
`define SDAA_PARAMS_SVH

// Width of the assigned device address field
`define SDAA_ADDR_W 4
// Lowest and highest individual address
`define SDAA_ADDR_MIN 4'h1
`define SDAA_ADDR_MAX 4'hE
// Broadcast address answered by every device
`define SDAA_ADDR_BCAST 4'hF
// Address held after reset, before any assignment
`define SDAA_ADDR_RESET 4'h0

`endif

// file: src/sdaa_pkg.sv
// Types shared by the address-assignment sequencer.
// Assumes the params header is compiled with it.
package sdaa_pkg;
	// Configuration states of the device
	typedef enum logic [1:0] {
		SDAA_STARTUP,
		SDAA_CONFIG1,
		SDAA_CONFIG2
	} sdaa_state_t;
endpackage

// file: src/sdaa_match.sv
// Address match for one decoded command frame.
// Assumes the frame's address field is stable while a command pulse is high.
`timescale 1ns/1ps
`include "sdaa_params.svh"

module sdaa_match (
	input wire logic [3:0] frame_addr_i,
	input wire logic [3:0] own_addr_i,
	output logic hit_o,
	output logic bcast_o
);
	// Broadcast hits all devices whatever they hold
	always_comb begin
		bcast_o = (frame_addr_i == `SDAA_ADDR_BCAST);
		hit_o = bcast_o || (frame_addr_i == own_addr_i);
	end
endmodule

// file: tb/sdaa_host_model.sv
// Host controller model: turns bench requests into one-cycle command pulses.
// Assumes one-cycle requests on req_i; 1 is a write, 2 an advance.
`timescale 1ns/1ps
module sdaa_host_model (
	input wire logic clock_i,
	input wire logic [1:0] req_i,
	input wire logic pwm_i,
	input wire logic [3:0] addr_i,
	input wire logic [3:0] data_i,
	output logic pwm_o = 1'h0,
	output logic wr_o = 1'h0,
	output logic adv_o = 1'h0,
	output logic [3:0] addr_o = 4'h0,
	output logic [3:0] data_o = 4'h0
);
	// Idle fields flip each cycle so a stale value never looks valid
	always_ff @(posedge clock_i) begin
		wr_o <= (req_i == 2'h1);
		adv_o <= (req_i == 2'h2);
		pwm_o <= pwm_i;
		addr_o <= (req_i != 2'h0) ? addr_i : ~addr_o;
		data_o <= (req_i != 2'h0) ? data_i : ~data_o;
	end
endmodule

// file: tb/sdaa_core_tb.sv
// Bench for the address sequencer: host model in front, model of the rules.
// Assumes the core answers one cycle after each command pulse.
`timescale 1ns/1ps
module sdaa_core_tb;
	logic clock_i = 0, rst_i = 1, done = 0, pwm = 0, wr, adv, pw;
	// Fault flag handed to the core together with startup done
	logic sfault = 0;
	logic [1:0] req = 0;
	logic [3:0] fa = 0, dat = 0, ha, hd, addr_o;
	logic locked, cfg2, hit;
	logic [1:0] flt;
	int n_mismatch = 0, total_checks = 0, own = 0, st = 0;
	sdaa_host_model i_sdaa_host_model (.clock_i(clock_i), .req_i(req), .pwm_i(pwm),
		.addr_i(fa), .data_i(dat), .pwm_o(pw), .wr_o(wr), .adv_o(adv), .addr_o(ha),
		.data_o(hd));
	sdaa_core i_sdaa_core (.clock_i(clock_i), .rst_i(rst_i), .startup_done_i(done),
		.startup_fault_i(sfault), .pwm_noninv_i(pw), .write_address_command_i(wr),
		.cfg_advance_cmd_i(adv), .frame_addr_i(ha), .cmd_addr_data_i(hd),
		.assigned_device_address_o(addr_o), .addr_locked_o(locked),
		.fault_indicator_outputs_o(flt), .config2_o(cfg2), .frame_hit_o(hit));
	// Clock at 50 MHz
	initial begin
		forever #10 clock_i = ~clock_i;
	end
	task chk(input logic [3:0] s, input logic [3:0] e);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// One command through the host, then compare with the rule model.
	// Called in the time step of a rising edge; returns at a later one.
	task op(input int k, input int p, input int a, input int d);
		int m;
		req <= k[1:0];
		pwm <= p[0];
		fa <= a[3:0];
		dat <= d[3:0];
		// Host turns the request into a pulse one edge later
		@(posedge clock_i) req <= 2'h0;
		// Core takes the pulse here; its answers stand for the next cycle
		@(posedge clock_i);
		#1;
		m = (a == own || a == 15);
		chk(hit, m);
		if (k == 1 && st == 1 && p == 1 && m && d >= 1 && d <= 14) own = d;
		if (k == 2 && st == 1 && a == 15) st = 2;
		chk(addr_o, own);
		chk(cfg2, st == 2);
		chk(locked, st == 2);
		chk(flt, (st != 0) ? 2'h3 : 2'h0);
		@(posedge clock_i);
	endtask
	// Watchdog
	initial begin
		#200000;
		n_mismatch++;
		test_done;
	end
	initial begin
		void'($urandom(69));
		repeat (16) @(posedge clock_i);
		rst_i <= 0;
		op(1, 1, 15, 5);
		// Startup that ends in a fault: indicators stay low, no addressing
		sfault <= 1'h1;
		done <= 1'h1;
		@(posedge clock_i) done <= 1'h0;
		sfault <= 1'h0;
		@(posedge clock_i);
		#1 chk(flt, 2'h0);
		@(posedge clock_i);
		op(1, 1, 0, 7);
		// Clean startup: indicators rise on the edge where the core sees done
		done <= 1'h1;
		@(posedge clock_i) done <= 1'h0;
		#1 chk(flt, 2'h3);
		st = 1;
		@(posedge clock_i);
		repeat (60) op(1, $urandom % 4 != 0, ($urandom % 3 == 0) ? 15 :
			($urandom % 2 ? own : $urandom % 16), $urandom % 16);
		op(2, 1, own, 0);
		op(2, 1, 15, 0);
		op(1, 1, 15, 9);
		#1 chk(flt, 2'h3);
		test_done;
	end
endmodule
